// file: src/dpcp_top.sv
`include "dpcp_consts.svh"

// What this block does
// (R1) Add programmed phase offset to each pixel
// (R2) Separate offsets for base and supplementary frames
// (R3) Offset correction on after reset, bypassable
// (R4) Thermal term from two slopes, deltas, scale
// (R5) Sensor and external illumination temperatures used
// (R6) Store both calibration temperatures
// (R7) Thermal correction on after reset, bypassable
// (R8) Slope shifted left by precision minus eight
// (R9) Output phase sums enabled corrections, wraps
// (R10) Range extension corrects each frequency first
// (R11) Own correction path per modulation frequency
// (R12) Supplementary slopes derived from base slopes
// (R13) Extension off streams individual frame data
// (R14) Outputs change on selected output clock edge
// (R15) Eight, four or one-lane serial pin use
// (R16) Row sync marks row data in parallel modes
// (R17) Frame sync marks each frame start
// (R18) Pixel is amplitude, ambient, phase, flags
// (R19) Amplitude word bytes 0-1, phase 2-3
// (R20) Ambient bits above amplitude bits
// (R21) Flag bits above phase bits
// (R22) Words sent in groups of eight, or fewer when a row end closes the group
// (R23) Low byte of each word first
// (R24) Host rebuilds words low byte first
// (R25) Range extension puts upper phase in flags
// (R26) Flags: saturation, zero, frame counter
module dpcp_top
  import dpcp_pkg::*;
#(
  parameter int TEMP_W = 8,
  parameter int COEFF_W = 12,
  parameter int PREC_W = 4,
  parameter int SCALE_SHIFT = `DPCP_SCALE_SHIFT
) (
  input wire logic sys_clk_i,                                  // System clock, 25 MHz
  input wire logic sys_rst_i,                                  // Async reset, active high
  input wire logic out_port_clock_i,                           // Output port clock source
  input wire logic pix_valid_i,                                // Pixel offered
  output logic pix_ready_o,                                    // Pixel can be taken
  input wire logic [`DPCP_PH_W-1:0] pix_phase_i,               // Computed phase
  input wire logic [`DPCP_PH_W-1:0] pix_amp_i,                 // Amplitude
  input wire logic [`DPCP_AUX_W-1:0] pix_amb_i,                // Ambient
  input wire logic pix_sat_i,                                  // Pixel saturated
  input wire logic pix_supp_i,                                 // Pixel from supplementary frame
  input wire logic [`DPCP_AUX_W-1:0] pix_wrap_i,               // Upper extended phase bits
  input wire logic pix_frame_start_i,                          // First pixel of a frame
  input wire logic pix_row_end_i,                              // Last pixel of a row
  input wire logic signed [TEMP_W-1:0] sensor_temp_i,          // On-chip sensor temperature
  input wire logic signed [TEMP_W-1:0] illum_temp_i,           // External sensor temperature
  input wire logic signed [TEMP_W-1:0] illum_cal_temperature_i,  // Illumination calibration temp
  input wire logic signed [TEMP_W-1:0] sensor_cal_temperature_i, // Sensor calibration temp
  input wire logic signed [COEFF_W-1:0] illum_temp_slope_i,    // Base illumination slope
  input wire logic signed [COEFF_W-1:0] sensor_temp_slope_i,   // Base sensor slope
  input wire logic [PREC_W-1:0] slope_precision_i,             // Slope precision
  input wire logic [1:0] supp_ratio_shift_i,                   // Log2 of base/supp frequency ratio
  input wire logic [`DPCP_PH_W-1:0] base_freq_offset_i,        // Base frame phase offset
  input wire logic [`DPCP_PH_W-1:0] supp_freq_offset_i,        // Supplementary frame phase offset
  input wire logic offset_fix_off_i,                           // Bypass offset correction
  input wire logic thermal_fix_off_i,                          // Bypass thermal correction
  input wire logic range_extend_on_i,                          // Range extension enable
  input wire logic [1:0] lane_mode_i,                          // 0 eight, 1 four, 2 one lane
  input wire logic fall_edge_i,                                // Outputs change on falling edge
  output logic [`DPCP_PH_W-1:0] supp_phase_o,                  // Corrected supplementary phase
  output logic supp_phase_valid_o,                             // Supplementary phase strobe
  output logic out_port_clock_o,                               // Forwarded output clock
  output logic [7:0] out_port_pins_o,                          // Output data pins
  output logic row_sync_o,                                     // Row sync
  output logic frame_sync_o                                    // Frame sync
);

  dpcp_sys_t s_q;
  dpcp_sys_t s_d;
  dpcp_link_t l_q;
  dpcp_link_t l_d;
  logic [1:0] lrst_q;
  logic l_rst;
  logic take;
  logic [`DPCP_PH_W-1:0] corr_base;
  logic [`DPCP_PH_W-1:0] corr_supp;
  logic [`DPCP_PH_W-1:0] phase_sum;
  logic [`DPCP_AUX_W-1:0] flags;
  logic [1:0] fcnt_nx;
  logic signed [COEFF_W-1:0] supp_illum_slope;
  logic signed [COEFF_W-1:0] supp_sensor_slope;
  dpcp_lane_t lane;
  logic [3:0] step;
  logic [3:0] pos_nx;
  logic [3:0] w_last;
  logic [1:0] wi;
  logic [15:0] word16;
  logic [7:0] cur_byte;

  function automatic logic [3:0] lane_step(input dpcp_lane_t m);
    case (m)
      DPCP_LANE4: lane_step = 4'h4;
      DPCP_LANE1: lane_step = 4'h1;
      default: lane_step = 4'h8;
    endcase
  endfunction : lane_step

  // A lower supplementary frequency turns the same delay into less phase
  assign supp_illum_slope = illum_temp_slope_i >>> supp_ratio_shift_i; // see (R12)
  assign supp_sensor_slope = sensor_temp_slope_i >>> supp_ratio_shift_i;

  dpcp_corr #(
    .TEMP_W(TEMP_W),
    .COEFF_W(COEFF_W),
    .PREC_W(PREC_W),
    .SCALE_SHIFT(SCALE_SHIFT)
  ) u_corr_base ( // see (R11)
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .offset_i(base_freq_offset_i),
    .illum_temp_i(illum_temp_i), // see (R5)
    .sensor_temp_i(sensor_temp_i),
    .illum_cal_i(illum_cal_temperature_i),
    .sensor_cal_i(sensor_cal_temperature_i),
    .illum_slope_i(illum_temp_slope_i),
    .sensor_slope_i(sensor_temp_slope_i),
    .precision_i(slope_precision_i),
    .offset_off_i(offset_fix_off_i),
    .thermal_off_i(thermal_fix_off_i),
    .corr_o(corr_base)
  );

  dpcp_corr #(
    .TEMP_W(TEMP_W),
    .COEFF_W(COEFF_W),
    .PREC_W(PREC_W),
    .SCALE_SHIFT(SCALE_SHIFT)
  ) u_corr_supp ( // see (R11)
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .offset_i(supp_freq_offset_i),
    .illum_temp_i(illum_temp_i),
    .sensor_temp_i(sensor_temp_i),
    .illum_cal_i(illum_cal_temperature_i),
    .sensor_cal_i(sensor_cal_temperature_i),
    .illum_slope_i(supp_illum_slope),
    .sensor_slope_i(supp_sensor_slope),
    .precision_i(slope_precision_i),
    .offset_off_i(offset_fix_off_i),
    .thermal_off_i(thermal_fix_off_i),
    .corr_o(corr_supp)
  );

  // One pixel in flight across the domain crossing; pend is the back-pressure
  assign take = pix_valid_i && !s_q.pend;
  assign pix_ready_o = !s_q.pend;

  always_comb begin
    s_d = s_q;
    s_d.ack_s1 = l_q.seen;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.supp_vld = 1'b0;
    fcnt_nx = pix_frame_start_i ? s_q.fcnt + 2'h1 : s_q.fcnt;
    phase_sum = pix_phase_i + (pix_supp_i ? corr_supp : corr_base); // see (R1) (R2) (R9)
    if (range_extend_on_i) begin
      flags = pix_wrap_i; // see (R25)
    end else begin
      flags = {pix_sat_i, `DPCP_FLAG2_VALUE, fcnt_nx}; // see (R26)
    end
    if (s_q.pend && s_q.ack_s2 == s_q.req) begin
      s_d.pend = 1'b0;
    end
    if (take) begin
      s_d.fcnt = fcnt_nx;
      if (range_extend_on_i && pix_supp_i) begin
        // Corrected before the outside combiner merges the two frequencies
        s_d.supp_ph = phase_sum; // see (R10)
        s_d.supp_vld = 1'b1;
      end else begin
        s_d.word[`DPCP_AMP_LSB +: `DPCP_PH_W] = pix_amp_i; // see (R18) (R19)
        s_d.word[`DPCP_AMB_LSB +: `DPCP_AUX_W] = pix_amb_i; // see (R20)
        s_d.word[`DPCP_PH_LSB +: `DPCP_PH_W] = phase_sum;
        s_d.word[`DPCP_FLAG_LSB +: `DPCP_AUX_W] = flags; // see (R21)
        s_d.fstart = pix_frame_start_i;
        s_d.rend = pix_row_end_i;
        s_d.pend = 1'b1; // see (R13)
        s_d.req = ~s_q.req;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= `DPCP_SYS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign supp_phase_o = s_q.supp_ph;
  assign supp_phase_valid_o = s_q.supp_vld;

  // Reset release is resynchronised so link flops leave reset on a link edge
  always_ff @(posedge out_port_clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lrst_q <= `DPCP_LRST_ON;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end

  assign l_rst = lrst_q[1];

  always_comb begin
    l_d = l_q;
    l_d.req_s1 = s_q.req;
    l_d.req_s2 = l_q.req_s1;
    l_d.edge_s1 = fall_edge_i;
    l_d.edge_s2 = l_q.edge_s1;
    l_d.lane_s1 = lane_mode_i;
    l_d.lane_s2 = l_q.lane_s1;
    l_d.fsync = 1'b0;
    lane = dpcp_lane_t'(l_q.lane_s2);
    step = lane_step(lane);
    pos_nx = {1'b0, l_q.pos} + step;
    w_last = {l_q.n, 1'b0} - 4'h1;
    wi = 2'(l_q.w - l_q.n);
    // First half of the group carries amplitude words, second half phase words
    if (l_q.w < l_q.n) begin
      word16 = l_q.pbuf[l_q.w[1:0]][15:0]; // see (R22)
    end else begin
      word16 = l_q.pbuf[wi][31:16];
    end
    cur_byte = l_q.b ? word16[15:8] : word16[7:0]; // see (R23)
    case (l_q.st)
      L_IDLE: begin
        l_d.pins = 8'h00;
        l_d.rsync = l_q.rsync && !l_q.grp_rend; // see (R16)
        if (l_q.req_s2 != l_q.seen) begin
          // Word in s_q is stable while the sys side waits for this ack
          l_d.seen = l_q.req_s2;
          l_d.pbuf[l_q.n[1:0]] = s_q.word;
          l_d.n = l_q.n + 3'h1;
          l_d.fpend = l_q.fpend || s_q.fstart;
          l_d.grp_rend = s_q.rend;
          if (l_q.n == 3'(`DPCP_GROUP_PIX - 1) || s_q.rend) begin
            l_d.st = (l_q.fpend || s_q.fstart) ? L_FSYNC : L_SEND;
            l_d.w = 3'h0;
            l_d.b = 1'b0;
            l_d.pos = 3'h0;
          end
        end
      end
      L_FSYNC: begin
        l_d.fsync = 1'b1; // see (R17)
        l_d.fpend = 1'b0;
        l_d.st = L_SEND;
      end
      L_SEND: begin
        l_d.rsync = lane != DPCP_LANE1; // see (R16)
        case (lane) // see (R15)
          DPCP_LANE4: begin
            l_d.pins = {4'h0, l_q.pos[2] ? cur_byte[7:4] : cur_byte[3:0]};
          end
          DPCP_LANE1: begin
            l_d.pins = 8'h00;
            l_d.pins[3] = 1'b1;
            l_d.pins[4] = cur_byte[l_q.pos];
          end
          default: begin
            l_d.pins = cur_byte;
          end
        endcase
        if (pos_nx[3]) begin
          l_d.pos = 3'h0;
          if (l_q.b) begin
            l_d.b = 1'b0;
            if ({1'b0, l_q.w} == w_last) begin
              l_d.st = L_IDLE;
              l_d.n = 3'h0;
            end else begin
              l_d.w = l_q.w + 3'h1;
            end
          end else begin
            l_d.b = 1'b1;
          end
        end else begin
          l_d.pos = pos_nx[2:0];
        end
      end
      default: begin
        l_d.st = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge out_port_clock_i or posedge l_rst) begin
    if (l_rst) begin
      l_q <= `DPCP_LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Link flops change on the rising source edge; inverting the forwarded
  // clock makes that the falling edge seen by the host
  assign out_port_clock_o = out_port_clock_i ^ l_q.edge_s2; // see (R14)
  assign out_port_pins_o = l_q.pins;
  assign row_sync_o = l_q.rsync;
  assign frame_sync_o = l_q.fsync;

  offset_add_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R9)
    (take && !(range_extend_on_i && pix_supp_i)) |=>
      s_q.word[`DPCP_PH_LSB +: `DPCP_PH_W] == $past(pix_phase_i) + $past(pix_supp_i ? corr_supp : corr_base))
    else $error("phase field is not phase plus selected correction");

  pack_fields_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R19)
    (take && !(range_extend_on_i && pix_supp_i)) |=>
      s_q.word[`DPCP_AMP_LSB +: `DPCP_PH_W] == $past(pix_amp_i) &&
      s_q.word[`DPCP_AMB_LSB +: `DPCP_AUX_W] == $past(pix_amb_i))
    else $error("amplitude or ambient misplaced in pixel word");

  plain_flags_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R26)
    (take && !range_extend_on_i) |=>
      s_q.word[`DPCP_FLAG_LSB + 3] == $past(pix_sat_i) && s_q.word[`DPCP_FLAG_LSB + 2] == 1'b0)
    else $error("saturation or reserved flag wrong");

  ext_flags_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R25)
    (take && range_extend_on_i && !pix_supp_i) |=> s_q.word[`DPCP_FLAG_LSB +: `DPCP_AUX_W] == $past(pix_wrap_i))
    else $error("upper phase bits not in flag field");

  stream_supp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R13)
    (take && !range_extend_on_i) |=> s_q.pend && !s_q.supp_vld)
    else $error("individual frame pixel not streamed");

  lane4_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R15)
    (l_q.st == L_SEND && lane == DPCP_LANE4) |=> out_port_pins_o[7:4] == 4'h0)
    else $error("upper pins driven in four-lane mode");

  lane1_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R15)
    (l_q.st == L_SEND && lane == DPCP_LANE1) |=>
      out_port_pins_o[3] && out_port_pins_o[7:5] == 3'h0 && out_port_pins_o[2:0] == 3'h0)
    else $error("serial select or unused pins wrong in one-lane mode");

  low_first_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R23)
    (l_q.st == L_SEND && lane == DPCP_LANE8 && !l_q.b) |=> out_port_pins_o == $past(cur_byte) && l_q.b)
    else $error("low byte not sent first");

  fsync_lead_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R17)
    frame_sync_o |-> l_q.st == L_SEND && l_q.w == 3'h0 && !l_q.b && l_q.pos == 3'h0)
    else $error("frame sync not directly ahead of group data");

  group_size_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R22)
    l_q.st == L_SEND |-> l_q.n != 3'h0 && l_q.n <= 3'(`DPCP_GROUP_PIX))
    else $error("group holds no pixel or too many");

  row_mark_a: assert property (@(posedge out_port_clock_i) disable iff (l_rst) // see (R16)
    (l_q.st == L_SEND && lane != DPCP_LANE1) |=> row_sync_o)
    else $error("row sync low during parallel row data");

endmodule : dpcp_top

// file: src/dpcp_consts.svh
`ifndef DPCP_CONSTS_SVH
`define DPCP_CONSTS_SVH

// Pixel word field positions
`define DPCP_AMP_LSB 0
`define DPCP_AMB_LSB 12
`define DPCP_PH_LSB 16
`define DPCP_FLAG_LSB 28
`define DPCP_PH_W 12
`define DPCP_AUX_W 4
`define DPCP_PIX_W 32

// Flag bit 2 always reads this value without range extension
`define DPCP_FLAG2_VALUE 1'b0

// Slope precision at which the programmed slope is used unshifted
`define DPCP_PREC_REF 8

// Calibration scale as a power of two
`define DPCP_SCALE_SHIFT 12

// Pixels held per group; two words each gives the group of eight words
`define DPCP_GROUP_PIX 4

// Reset values
`define DPCP_SYS_RST '0
`define DPCP_LINK_RST '0
`define DPCP_LRST_ON 2'h3

`endif

// file: src/dpcp_pkg.sv
`include "dpcp_consts.svh"

package dpcp_pkg;

  typedef enum logic [1:0] {DPCP_LANE8, DPCP_LANE4, DPCP_LANE1} dpcp_lane_t;

  typedef enum logic [1:0] {L_IDLE, L_FSYNC, L_SEND} dpcp_lstate_t;

  typedef struct packed {
    logic pend;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic [`DPCP_PIX_W-1:0] word;
    logic fstart;
    logic rend;
    logic [1:0] fcnt;
    logic [`DPCP_PH_W-1:0] supp_ph;
    logic supp_vld;
  } dpcp_sys_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic seen;
    logic edge_s1;
    logic edge_s2;
    logic [1:0] lane_s1;
    logic [1:0] lane_s2;
    dpcp_lstate_t st;
    logic [`DPCP_GROUP_PIX-1:0][`DPCP_PIX_W-1:0] pbuf;
    logic [2:0] n;
    logic fpend;
    logic grp_rend;
    logic [2:0] w;
    logic b;
    logic [2:0] pos;
    logic [7:0] pins;
    logic rsync;
    logic fsync;
  } dpcp_link_t;

  typedef struct packed {
    logic [`DPCP_PH_W-1:0] corr;
  } dpcp_corr_t;

endpackage : dpcp_pkg

// file: src/dpcp_corr.sv
`include "dpcp_consts.svh"

module dpcp_corr
  import dpcp_pkg::*;
#(
  parameter int TEMP_W = 8,
  parameter int COEFF_W = 12,
  parameter int PREC_W = 4,
  parameter int SCALE_SHIFT = `DPCP_SCALE_SHIFT
) (
  input wire logic sys_clk_i,                              // System clock
  input wire logic sys_rst_i,                              // Async reset, active high
  input wire logic [`DPCP_PH_W-1:0] offset_i,              // Phase offset for this frequency
  input wire logic signed [TEMP_W-1:0] illum_temp_i,       // Illumination temperature
  input wire logic signed [TEMP_W-1:0] sensor_temp_i,      // Sensor temperature
  input wire logic signed [TEMP_W-1:0] illum_cal_i,        // Illumination calibration temperature
  input wire logic signed [TEMP_W-1:0] sensor_cal_i,       // Sensor calibration temperature
  input wire logic signed [COEFF_W-1:0] illum_slope_i,     // Illumination slope
  input wire logic signed [COEFF_W-1:0] sensor_slope_i,    // Sensor slope
  input wire logic [PREC_W-1:0] precision_i,               // Slope precision
  input wire logic offset_off_i,                           // Offset correction bypass
  input wire logic thermal_off_i,                          // Thermal correction bypass
  output logic [`DPCP_PH_W-1:0] corr_o                     // Total correction, registered
);

  localparam int PW = COEFF_W + TEMP_W + 1 + 16;

  dpcp_corr_t c_q;
  dpcp_corr_t c_d;
  logic signed [TEMP_W:0] dt_illum;
  logic signed [TEMP_W:0] dt_sensor;
  logic signed [PW-1:0] sum;
  logic [`DPCP_PH_W-1:0] temp_term;

  // Shift left or right by the distance of the precision from its reference
  function automatic logic signed [PW-1:0] prec_scale(input logic signed [PW-1:0] v,
                                                      input logic [PREC_W-1:0] p);
    if (p >= PREC_W'(`DPCP_PREC_REF)) begin
      prec_scale = v <<< (p - PREC_W'(`DPCP_PREC_REF));
    end else begin
      prec_scale = v >>> (PREC_W'(`DPCP_PREC_REF) - p);
    end
  endfunction : prec_scale

  always_comb begin
    dt_illum = (TEMP_W+1)'(illum_temp_i) - (TEMP_W+1)'(illum_cal_i); // see (R6)
    dt_sensor = (TEMP_W+1)'(sensor_temp_i) - (TEMP_W+1)'(sensor_cal_i);
    sum = prec_scale(PW'(illum_slope_i) * PW'(dt_illum), precision_i) // see (R8)
        + prec_scale(PW'(sensor_slope_i) * PW'(dt_sensor), precision_i); // see (R4)
    temp_term = sum[SCALE_SHIFT +: `DPCP_PH_W];
    c_d.corr = (offset_off_i ? '0 : offset_i) // see (R3)
             + (thermal_off_i ? '0 : temp_term); // see (R7)
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign corr_o = c_q.corr;

  bypass_both_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R3) (R7)
    (offset_off_i && thermal_off_i) |=> corr_o == '0)
    else $error("correction not zero while both corrections bypassed");

  offset_only_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see (R1)
    (!offset_off_i && thermal_off_i) |=> corr_o == $past(offset_i))
    else $error("correction differs from offset with thermal term bypassed");

endmodule : dpcp_corr

// file: sim/dpcp_host_model.sv
module dpcp_host_model (
  input wire logic rst_i,                // Reset, active high
  input wire logic out_clk_i,            // Forwarded output clock
  input wire logic fall_mode_i,          // Device launches on falling edge
  input wire logic [1:0] lane_mode_i,    // Lane mode
  input wire logic [7:0] pins_i,         // Data pins
  input wire logic row_sync_i,           // Row sync
  input wire logic frame_sync_i,         // Frame sync
  output logic [7:0][15:0] words_o,      // Words of the last group
  output logic [3:0] n_words_o,          // Words taken this frame
  output logic [7:0] n_fsync_o           // Frame syncs seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] acc;
  logic [15:0] nxt;
  logic [4:0] nbit;
  logic [4:0] k;

  // Sample on the edge opposite the launch edge, so a late launch is caught
  always @(posedge out_clk_i or negedge out_clk_i or posedge rst_i) begin
    if (rst_i) begin
      words_o <= '0;
      n_words_o <= '0;
      n_fsync_o <= '0;
      acc <= '0;
      nbit <= '0;
    end else if (out_clk_i === fall_mode_i) begin
      if (frame_sync_i === 1'b1) begin
        n_fsync_o <= n_fsync_o + 8'h01;
        n_words_o <= '0;
        acc <= '0;
        nbit <= '0;
      end else if ((lane_mode_i == 2'h2 ? pins_i[3] : row_sync_i) === 1'b1) begin
        k = lane_mode_i == 2'h1 ? 5'h04 : (lane_mode_i == 2'h2 ? 5'h01 : 5'h08);
        nxt = acc | (16'(lane_mode_i == 2'h2 ? {7'h00, pins_i[4]} :
          (lane_mode_i == 2'h1 ? {4'h0, pins_i[3:0]} : pins_i)) << nbit);
        if (nbit + k == 5'h10) begin
          words_o[n_words_o[2:0]] <= nxt;
          n_words_o <= n_words_o + 4'h1;
          acc <= '0;
          nbit <= '0;
        end else begin
          acc <= nxt;
          nbit <= nbit + k;
        end
      end
    end
  end
endmodule : dpcp_host_model

// file: sim/dpcp_top_tb.sv
module dpcp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 0, sys_rst_i = 1, lclk = 0, valid = 0, sat = 0, supp = 0, fstart = 0, rend = 0;
  logic ofs_off = 0, th_off = 1, ext = 0, fall = 0;
  logic [11:0] phase = 0, amp = 0, boff = 0, soff = 0, supp_ph;
  logic [3:0] amb = 0, wrap = 0, prec = 4'h8, nw;
  logic signed [7:0] stemp = 0, itemp = 0, ical = 0, scal = 0;
  logic signed [11:0] islope = 0, sslope = 0;
  logic [1:0] rshift = 0, lane = 0, fcnt = 0;
  logic ready, supp_vld, oclk, rsync, fsync;
  logic [7:0] pins, nfs, nfs_exp = 0;
  logic [7:0][15:0] words;
  int failures = 0, n_tests = 0, cyc = 0;

  always #20 sys_clk_i = ~sys_clk_i;
  always #7.5 lclk = ~lclk;

  dpcp_top dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .out_port_clock_i(lclk),
    .pix_valid_i(valid), .pix_ready_o(ready), .pix_phase_i(phase), .pix_amp_i(amp), .pix_amb_i(amb),
    .pix_sat_i(sat), .pix_supp_i(supp), .pix_wrap_i(wrap), .pix_frame_start_i(fstart),
    .pix_row_end_i(rend), .sensor_temp_i(stemp), .illum_temp_i(itemp), .illum_cal_temperature_i(ical),
    .sensor_cal_temperature_i(scal), .illum_temp_slope_i(islope), .sensor_temp_slope_i(sslope),
    .slope_precision_i(prec), .supp_ratio_shift_i(rshift), .base_freq_offset_i(boff),
    .supp_freq_offset_i(soff), .offset_fix_off_i(ofs_off), .thermal_fix_off_i(th_off),
    .range_extend_on_i(ext), .lane_mode_i(lane), .fall_edge_i(fall), .supp_phase_o(supp_ph),
    .supp_phase_valid_o(supp_vld), .out_port_clock_o(oclk), .out_port_pins_o(pins),
    .row_sync_o(rsync), .frame_sync_o(fsync));

  dpcp_host_model host_u (.rst_i(sys_rst_i), .out_clk_i(oclk), .fall_mode_i(fall), .lane_mode_i(lane),
    .pins_i(pins), .row_sync_i(rsync), .frame_sync_i(fsync), .words_o(words), .n_words_o(nw),
    .n_fsync_o(nfs));

  task report_and_stop;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task tick;
    @(posedge sys_clk_i);
    #1;
  endtask : tick

  task put_pix(input logic [11:0] ph, input int i, input logic sp, input logic fs, input logic re);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 400) begin
      tick;
      k++;
    end
    {valid, phase, amp, amb, wrap, sat, supp, fstart, rend} = {1'b1, ph, 12'h3a0 + 12'(i), 4'(i + 9),
      4'(i + 3), i == 2, sp, fs, re};
    tick;
    {valid, fstart, rend} = 3'h0;
  endtask : put_pix

  // One frame of one row: four pixels, pixel 1 supplementary unless extending
  task run_group(input logic [11:0] ph0, input logic [11:0] cb, input logic [11:0] cs, input logic x);
    logic [3:0] fl;
    int k;
    fcnt++;
    nfs_exp++;
    repeat (8) tick;
    for (int i = 0; i < 4; i++) put_pix(ph0 + 12'(i * 'h123), i, i == 1 && !x, i == 0, i == 3);
    k = 0;
    // Word count only restarts at the frame sync, so wait for that sync first
    while ((nfs !== nfs_exp || nw !== 4'h8) && k < 800) begin
      tick;
      k++;
    end
    tick;
    chk("words taken", 16'h0008, {12'h000, nw});
    chk("row sync after row end", 16'h0000, {15'h0000, rsync});
    for (int i = 0; i < 4; i++) begin
      fl = x ? 4'(i + 3) : {i == 2, 1'b0, fcnt};
      chk("amplitude word", {4'(i + 9), 12'h3a0 + 12'(i)}, words[i]);
      chk("phase word", {fl, ph0 + 12'(i * 'h123) + ((i == 1 && !x) ? cs : cb)}, words[i + 4]);
    end
    chk("frame syncs", {8'h00, nfs_exp}, {8'h00, nfs});
  endtask : run_group

  task sc_offset;
    {lane, fall, ofs_off, th_off, boff, soff} = {2'h0, 1'b0, 1'b0, 1'b1, 12'h100, 12'h0a5};
    run_group(12'hf80, 12'h100, 12'h0a5, 1'b0);
  endtask : sc_offset

  task sc_bypass;
    {lane, fall, ofs_off} = {2'h1, 1'b1, 1'b1};
    run_group(12'h123, 12'h000, 12'h000, 1'b0);
  endtask : sc_bypass

  // Both terms give 2 before the precision shift of 2, so a lost shift shows
  task sc_thermal;
    {lane, fall, th_off, rshift, prec} = {2'h2, 1'b0, 1'b0, 2'h1, 4'ha};
    {itemp, ical, islope, stemp, scal, sslope} = {8'sd40, 8'sd8, 12'sh100, 8'sd20, 8'sd4, 12'sh200};
    run_group(12'h200, 12'h010, 12'h008, 1'b0);
  endtask : sc_thermal

  task sc_extend;
    int k;
    {lane, ext, th_off, ofs_off} = {2'h0, 1'b1, 1'b1, 1'b0};
    repeat (8) tick;
    put_pix(12'h7f0, 0, 1'b1, 1'b0, 1'b0);
    k = 0;
    while (supp_vld !== 1'b1 && k < 8) begin
      tick;
      k++;
    end
    chk("supp phase valid", 16'h0001, {15'h0000, supp_vld});
    chk("supp phase", {4'h0, 12'h7f0 + soff}, {4'h0, supp_ph});
    run_group(12'h050, boff, soff, 1'b1);
  endtask : sc_extend

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 0;
    sc_offset;
    sc_bypass;
    sc_thermal;
    sc_extend;
    report_and_stop;
  end
endmodule : dpcp_top_tb
